// File: design/wss_pkg.sv
package wss_pkg;
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_OFFS = 12'h004;
	localparam logic [11:0] A_STAT = 12'h008;
	localparam logic [11:0] A_ECLR = 12'h00c;
	localparam int MEM_BIT = 11;
	localparam int C_SCHED = 0;
	localparam int C_EXT = 8;
	localparam int C_ESTOP = 9;
	localparam int C_AOO = 10;
	localparam int C_WBEAT = 12;
	localparam int C_MAXOFF = 16;
	localparam int O_IOFF = 0;
	localparam int O_CALL = 8;
	localparam int O_EDIT = 16;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] OFFS_RST = 32'h0000_0000;
	// Schedule word layout: four 7-bit field slot positions, shared in some words with flag, valve, mode and current fields
	localparam int F0 = 0;
	localparam int F1 = 8;
	localparam int F2 = 16;
	localparam int F3 = 24;
	localparam int F_VALVE = 16;
	localparam int F_CMODE = 20;
	localparam int F_MODE = 7;
	localparam int F_MON = 14;
	localparam int F_PMON = 15;
	localparam logic [2:0] W_SQ = 3'h0;
	localparam logic [2:0] W_W1 = 3'h1;
	localparam logic [2:0] W_I1 = 3'h2;
	localparam logic [2:0] W_L1 = 3'h3;
	localparam logic [2:0] W_W2 = 3'h4;
	localparam logic [2:0] W_I2 = 3'h5;
	localparam logic [2:0] W_L2 = 3'h6;
	localparam logic [2:0] W_OFF = 3'h7;
	localparam logic [3:0] LOAD_END = 4'h8;
	localparam logic [6:0] WAIT_CNT = 7'h63;
	localparam logic [5:0] SCHED_ALT = 6'h14;
	localparam logic [1:0] AOO_M2 = 2'h2;
	localparam int PCT = 100;
	typedef enum logic [2:0] {
		CM_NONREP = 3'h0,
		CM_REP = 3'h1,
		CM_CHAIN = 3'h2,
		CM_SUCC = 3'h3,
		CM_WAIT = 3'h4
	} wss_cmode_t;
	typedef enum logic [11:0] {
		ST_IDLE = 12'h001,
		ST_LOAD = 12'h002,
		ST_SQD = 12'h004,
		ST_SQZ = 12'h008,
		ST_W1 = 12'h010,
		ST_C1 = 12'h020,
		ST_SLP = 12'h040,
		ST_W2 = 12'h080,
		ST_C2 = 12'h100,
		ST_HOLD = 12'h200,
		ST_BLK = 12'h400,
		ST_OFF = 12'h800
	} wss_state_t;
endpackage

// File: design/wss_sched_mem.sv
`timescale 1ns/1ps
module wss_sched_mem #(
	parameter int WIDTH = 32,
	parameter int AW = 9
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata_q
);
	logic [WIDTH-1:0] mem [2**AW];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= mem[raddr];
		end
	end
endmodule

// File: design/wss_sequencer.sv
`timescale 1ns/1ps
// How it works
// [R1] Schedule index 0-63, locked when external
// [R2] Squeeze delay only before first repeat weld
// [R3] Squeeze count between valves and current
// [R4] Valve mask selects any valve combination
// [R5] Heat percent or current setpoint per mode
// [R6] High/low current band flags error
// [R7] First weld pre-low count raises error
// [R8] Main weld pre-low count raises error
// [R9] Phase shift outside limits flags error
// [R10] First cool without current before main
// [R11] Slope ramps heat between weld levels
// [R12] Second cool after every main impulse
// [R13] Main plus cool repeated impulse times
// [R14] Hold keeps valves on, no current
// [R15] Off releases valves, blocks next start
// [R16] Signed offset clamped to configured maximum
// [R17] Offset applies to all or edited
// [R18] Non-repeat runs once per initiation
// [R19] Repeat restarts while initiation held
// [R20] Chained and successive schedule advance
// [R21] Wait-here count 99 waits for escape
// [R22] Air-over-oil swaps advance and intensify
// [R23] Second air-over-oil mode adds block delay
// [R24] External index from pins, second input 20
// [R25] Stop policy refuses welds until an error clear write
// [R26] Phases counted in line cycles, zero skipped
// [R27] Fixed phase order through off
module wss_sequencer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic line_zero,
	input wire logic first_initiation_input,
	input wire logic second_initiation_input,
	input wire logic escape_in,
	input wire logic schedule_bit_input_a,
	input wire logic schedule_bit_input_b,
	input wire logic schedule_bit_input_c,
	input wire logic schedule_bit_input_d,
	input wire logic [13:0] meas_current,
	input wire logic [6:0] phase_needed,
	output logic [2:0] valve_out,
	output logic weld_on,
	output logic const_current,
	output logic [6:0] heat_pct,
	output logic [13:0] current_set
);
	wss_pkg::wss_state_t st_q, st_d;
	logic [31:0] ctrl_q, offs_q, mem_rd;
	logic [31:0] sw_q [8];
	logic [5:0] run_q, run_d, succ_q, err_q, err_set;
	logic succ_v_q, first_q, armed_q, lock_q, mack_q, lz_q;
	logic [3:0] ld_q;
	logic [6:0] cyc_q, imp_q, pl1_q, pl2_q, cnt, heat_q;
	logic [2:0] valve_q;
	logic weld_q, cc_q;
	logic [13:0] cur_q;

	function automatic logic [6:0] fld(input logic [31:0] w, input int lsb);
		return w[lsb +: 7];
	endfunction

	function automatic logic above(input logic [13:0] m, input logic [13:0] s, input logic [6:0] p);
		return int'(m) * wss_pkg::PCT > int'(s) * (wss_pkg::PCT + int'(p));
	endfunction

	function automatic logic below(input logic [13:0] m, input logic [13:0] s, input logic [6:0] p);
		return int'(m) * wss_pkg::PCT < int'(s) * (wss_pkg::PCT - int'(p));
	endfunction

	function automatic logic [13:0] scale(input logic [13:0] c, input int o);
		return 14'((int'(c) * (wss_pkg::PCT + o)) / wss_pkg::PCT);
	endfunction

	function automatic int lerp(input int a, input int b, input int k, input int n);
		return a + ((b - a) * k) / n;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register bus
	wire acc = psel & penable;
	wire mem_sel = paddr[wss_pkg::MEM_BIT];
	wire sel_ctrl = !mem_sel && paddr == wss_pkg::A_CTRL;
	wire sel_offs = !mem_sel && paddr == wss_pkg::A_OFFS;
	wire sel_stat = !mem_sel && paddr == wss_pkg::A_STAT;
	wire sel_eclr = !mem_sel && paddr == wss_pkg::A_ECLR;
	wire known = mem_sel | sel_ctrl | sel_offs | sel_stat | sel_eclr;
	wire wr_ctrl = acc & pwrite & sel_ctrl;
	wire wr_offs = acc & pwrite & sel_offs;
	wire eclr = acc & pwrite & sel_eclr;
	wire mem_we = acc & pwrite & mem_sel;
	wire busy = st_q != wss_pkg::ST_IDLE;
	wire loading = st_q == wss_pkg::ST_LOAD;
	wire [31:0] stat_w = {10'h0, err_q, 6'h0, lock_q, busy, 2'h0, run_q};
	wire [8:0] mem_ra = loading ? {run_q, ld_q[2:0]} : paddr[10:2];
	wire [31:0] ctrl_w = {pwdata[31:6], ctrl_q[8] ? ctrl_q[5:0] : pwdata[5:0]}; // R1

	assign pready = !(mem_sel && !pwrite) || mack_q;
	assign pslverr = acc & !known;
	assign prdata = mem_sel ? mem_rd : sel_ctrl ? ctrl_q : sel_offs ? offs_q : sel_stat ? stat_w : 32'h0;

	wss_sched_mem #(.WIDTH(32), .AW(9)) u_mem (
		.clk(pclk),
		.rst_n(presetn),
		.we(mem_we),
		.waddr(paddr[10:2]),
		.wdata(pwdata),
		.raddr(mem_ra),
		.rdata_q(mem_rd)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Configuration and schedule fields
	wire ext_sel = ctrl_q[wss_pkg::C_EXT];
	wire estop = ctrl_q[wss_pkg::C_ESTOP];
	wire [1:0] aoo = ctrl_q[wss_pkg::C_AOO +: 2];
	wire aoo_on = aoo != 2'h0;
	wire wbeat = ctrl_q[wss_pkg::C_WBEAT];
	wire [3:0] max_off = ctrl_q[wss_pkg::C_MAXOFF +: 4];
	wire [4:0] ioff = offs_q[wss_pkg::O_IOFF +: 5];
	wire off_all = offs_q[wss_pkg::O_CALL];
	wire [5:0] edit_idx = offs_q[wss_pkg::O_EDIT +: 6];
	wire [2:0] cmode = sw_q[wss_pkg::W_SQ][wss_pkg::F_CMODE +: 3];
	wire [2:0] valve_sel = sw_q[wss_pkg::W_SQ][wss_pkg::F_VALVE +: 3]; // R4
	wire [6:0] n_imp = fld(sw_q[wss_pkg::W_SQ], wss_pkg::F3);
	wire mode1 = sw_q[wss_pkg::W_W1][wss_pkg::F_MODE];
	wire mode2 = sw_q[wss_pkg::W_W2][wss_pkg::F_MODE];
	wire [6:0] heat1 = fld(sw_q[wss_pkg::W_W1], wss_pkg::F1);
	wire [6:0] heat2 = fld(sw_q[wss_pkg::W_W2], wss_pkg::F1);
	wire [6:0] slope = fld(sw_q[wss_pkg::W_W1], wss_pkg::F3);
	wire [31:0] i1 = sw_q[wss_pkg::W_I1];
	wire [31:0] i2 = sw_q[wss_pkg::W_I2];
	wire [31:0] l1 = sw_q[wss_pkg::W_L1];
	wire [31:0] l2 = sw_q[wss_pkg::W_L2];
	wire mon1 = i1[wss_pkg::F_MON];
	wire mon2 = i2[wss_pkg::F_MON];
	wire [6:0] plc1 = fld(l1, wss_pkg::F1);
	wire [6:0] plc2 = fld(l2, wss_pkg::F1);

	// Current offset, clamped and gated
	wire apply_off = max_off != 4'h0 && (off_all || run_q == edit_idx); // R17
	wire signed [5:0] off_s = $signed({ioff[4], ioff});
	wire signed [5:0] off_m = $signed({2'h0, max_off});
	wire signed [5:0] off_c = off_s > off_m ? off_m : off_s < -off_m ? -off_m : off_s; // R16
	wire signed [5:0] off_e = apply_off ? off_c : 6'sh0;
	wire [13:0] tgt1 = scale(i1[13:0], int'(off_e)); // R16
	wire [13:0] tgt2 = scale(i2[13:0], int'(off_e));

	////////////////////////////////////////////////////////////////////////////////
	// Phase timing
	wire zc = line_zero & !lz_q; // R26
	wire init_any = first_initiation_input | second_initiation_input;
	wire [3:0] ext_idx = {schedule_bit_input_d, schedule_bit_input_c, schedule_bit_input_b, schedule_bit_input_a};

	always_comb begin
		unique case (st_q)
			wss_pkg::ST_IDLE, wss_pkg::ST_LOAD: cnt = 7'h0;
			wss_pkg::ST_SQD: cnt = !first_q ? 7'h0 : aoo_on ? fld(sw_q[wss_pkg::W_OFF], wss_pkg::F1) :
				fld(sw_q[wss_pkg::W_SQ], wss_pkg::F0); // R2 R22
			wss_pkg::ST_SQZ: cnt = aoo_on ? fld(sw_q[wss_pkg::W_OFF], wss_pkg::F2) :
				fld(sw_q[wss_pkg::W_SQ], wss_pkg::F1); // R3 R22
			wss_pkg::ST_W1: cnt = fld(sw_q[wss_pkg::W_W1], wss_pkg::F0);
			wss_pkg::ST_C1: cnt = fld(sw_q[wss_pkg::W_W1], wss_pkg::F2); // R10
			wss_pkg::ST_SLP: cnt = slope;
			wss_pkg::ST_W2: cnt = fld(sw_q[wss_pkg::W_W2], wss_pkg::F0);
			wss_pkg::ST_C2: cnt = fld(sw_q[wss_pkg::W_W2], wss_pkg::F2); // R12
			wss_pkg::ST_HOLD: cnt = fld(sw_q[wss_pkg::W_W2], wss_pkg::F3); // R14
			wss_pkg::ST_BLK: cnt = fld(sw_q[wss_pkg::W_OFF], wss_pkg::F3); // R23
			wss_pkg::ST_OFF: cnt = fld(sw_q[wss_pkg::W_OFF], wss_pkg::F0); // R15
			default: cnt = 7'h0;
		endcase
	end

	wire waitable = !(st_q inside {wss_pkg::ST_IDLE, wss_pkg::ST_LOAD, wss_pkg::ST_SLP, wss_pkg::ST_BLK, wss_pkg::ST_OFF});
	wire wait_hold = cmode == wss_pkg::CM_WAIT && wbeat && cnt == wss_pkg::WAIT_CNT && waitable; // R21
	wire esc_chain = wait_hold & escape_in; // R21
	wire done = wait_hold ? escape_in : (cnt == 7'h0 || (zc && {1'b0, cyc_q} + 8'h1 >= {1'b0, cnt})); // R26
	wire again = cmode == wss_pkg::CM_CHAIN || (cmode == wss_pkg::CM_REP && init_any); // R19 R20
	wire start = armed_q && init_any && !lock_q; // R18 R25
	wire [5:0] base_idx = succ_v_q ? succ_q : ctrl_q[wss_pkg::C_SCHED +: 6];
	wire [5:0] start_idx = second_initiation_input ? wss_pkg::SCHED_ALT : ext_sel ? {2'h0, ext_idx} : base_idx; // R24

	// Phase sequence
	always_comb begin
		st_d = st_q;
		run_d = run_q;
		unique case (st_q)
			wss_pkg::ST_IDLE: if (start) begin
				st_d = wss_pkg::ST_LOAD;
				run_d = start_idx;
			end
			wss_pkg::ST_LOAD: if (ld_q == wss_pkg::LOAD_END) st_d = wss_pkg::ST_SQD;
			wss_pkg::ST_SQD: if (done) st_d = wss_pkg::ST_SQZ; // R27
			wss_pkg::ST_SQZ: if (done) st_d = wss_pkg::ST_W1;
			wss_pkg::ST_W1: if (done) st_d = wss_pkg::ST_C1;
			wss_pkg::ST_C1: if (done) st_d = wss_pkg::ST_SLP;
			wss_pkg::ST_SLP: if (done) st_d = wss_pkg::ST_W2;
			wss_pkg::ST_W2: if (done) st_d = wss_pkg::ST_C2;
			wss_pkg::ST_C2: if (done) st_d = imp_q + 7'h1 < n_imp ? wss_pkg::ST_W2 : wss_pkg::ST_HOLD; // R13
			wss_pkg::ST_HOLD: if (done) st_d = aoo == wss_pkg::AOO_M2 ? wss_pkg::ST_BLK : wss_pkg::ST_OFF; // R23
			wss_pkg::ST_BLK: if (done) st_d = wss_pkg::ST_OFF;
			wss_pkg::ST_OFF: if (done) begin
				st_d = again && !lock_q ? wss_pkg::ST_LOAD : wss_pkg::ST_IDLE; // R15 R19 R20
				run_d = cmode == wss_pkg::CM_CHAIN ? run_q + 6'h1 : run_q;
			end
			default: st_d = wss_pkg::ST_IDLE;
		endcase
		if (esc_chain) begin
			st_d = wss_pkg::ST_LOAD;
			run_d = run_q + 6'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Monitors
	wire in_w1 = st_q == wss_pkg::ST_W1 && zc;
	wire in_w2 = st_q == wss_pkg::ST_W2 && zc;
	wire pre1 = below(meas_current, tgt1, fld(l1, wss_pkg::F0));
	wire pre2 = below(meas_current, tgt2, fld(l2, wss_pkg::F0));
	wire ph1 = phase_needed > fld(l1, wss_pkg::F2) || phase_needed < fld(l1, wss_pkg::F3);
	wire ph2 = phase_needed > fld(l2, wss_pkg::F2) || phase_needed < fld(l2, wss_pkg::F3);

	always_comb begin
		err_set[0] = in_w1 && mon1 && (above(meas_current, tgt1, fld(i1, wss_pkg::F2)) ||
			below(meas_current, tgt1, fld(i1, wss_pkg::F3))); // R6
		err_set[1] = in_w2 && mon2 && (above(meas_current, tgt2, fld(i2, wss_pkg::F2)) ||
			below(meas_current, tgt2, fld(i2, wss_pkg::F3))); // R6
		// Raised on the crossing that brings the count to its limit, so an error clear sticks
		err_set[2] = in_w1 && mon1 && pre1 && plc1 != 7'h0 && pl1_q + 7'h1 == plc1; // R7
		err_set[3] = in_w2 && mon2 && pre2 && plc2 != 7'h0 && pl2_q + 7'h1 == plc2; // R8
		err_set[4] = in_w1 && i1[wss_pkg::F_PMON] && ph1; // R9
		err_set[5] = in_w2 && i2[wss_pkg::F_PMON] && ph2; // R9
	end

	// Drive values for the power stage
	wire slp = st_q == wss_pkg::ST_SLP;
	wire [6:0] heat_ramp = 7'(lerp(int'(heat1), int'(heat2), int'(cyc_q) + 1, int'(slope) + 1)); // R11
	wire [13:0] cur_ramp = 14'(lerp(int'(tgt1), int'(tgt2), int'(cyc_q) + 1, int'(slope) + 1));
	wire use2 = st_q == wss_pkg::ST_W2 || slp;
	wire cc = use2 ? mode2 : mode1;
	wire firing = st_q inside {wss_pkg::ST_W1, wss_pkg::ST_SLP, wss_pkg::ST_W2} && cnt != 7'h0; // R26
	wire vopen = st_q inside {wss_pkg::ST_SQD, wss_pkg::ST_SQZ, wss_pkg::ST_W1, wss_pkg::ST_C1,
		wss_pkg::ST_SLP, wss_pkg::ST_W2, wss_pkg::ST_C2, wss_pkg::ST_HOLD};
	wire [6:0] heat_d = slp ? heat_ramp : use2 ? heat2 : heat1;
	wire [13:0] cur_d = slp ? cur_ramp : use2 ? tgt2 : tgt1;

	assign valve_out = valve_q;
	assign weld_on = weld_q;
	assign const_current = cc_q;
	assign heat_pct = heat_q;
	assign current_set = cur_q;

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= wss_pkg::CTRL_RST;
			offs_q <= wss_pkg::OFFS_RST;
			err_q <= 6'h0;
			lock_q <= 1'b0;
			mack_q <= 1'b0;
		end else begin
			if (wr_ctrl) ctrl_q <= ctrl_w;
			if (wr_offs) offs_q <= pwdata;
			err_q <= (err_q & ~(eclr ? pwdata[21:16] : 6'h0)) | err_set;
			lock_q <= (lock_q && !eclr) || (estop && err_set != 6'h0); // R25
			mack_q <= acc && mem_sel && !pwrite && !mack_q && !loading;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= wss_pkg::ST_IDLE;
			run_q <= 6'h0;
			ld_q <= 4'h0;
			lz_q <= 1'b0;
			armed_q <= 1'b0;
			first_q <= 1'b0;
			succ_q <= 6'h0;
			succ_v_q <= 1'b0;
		end else begin
			st_q <= st_d;
			run_q <= run_d;
			lz_q <= line_zero;
			ld_q <= loading ? ld_q + 4'h1 : 4'h0;
			armed_q <= !init_any || (armed_q && !start); // R18
			if (st_q != wss_pkg::ST_LOAD && st_d == wss_pkg::ST_LOAD) first_q <= !(st_q == wss_pkg::ST_OFF &&
				cmode == wss_pkg::CM_REP); // R2
			if (st_q == wss_pkg::ST_OFF && st_d == wss_pkg::ST_IDLE) begin
				succ_v_q <= cmode == wss_pkg::CM_SUCC; // R20
				succ_q <= run_q + 6'h1;
			end
			if (wr_ctrl) succ_v_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++) sw_q[i] <= 32'h0;
		end else if (loading && ld_q != 4'h0) begin
			sw_q[3'(ld_q - 4'h1)] <= mem_rd;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc_q <= 7'h0;
			imp_q <= 7'h0;
			pl1_q <= 7'h0;
			pl2_q <= 7'h0;
		end else begin
			cyc_q <= st_d != st_q ? 7'h0 : zc ? cyc_q + 7'h1 : cyc_q; // R26
			imp_q <= loading ? 7'h0 : (st_q == wss_pkg::ST_C2 && st_d == wss_pkg::ST_W2) ? imp_q + 7'h1 : imp_q; // R13
			pl1_q <= loading ? 7'h0 : (in_w1 && mon1 && pre1 && pl1_q != 7'h7f) ? pl1_q + 7'h1 : pl1_q; // R7
			pl2_q <= loading ? 7'h0 : (in_w2 && mon2 && pre2 && pl2_q != 7'h7f) ? pl2_q + 7'h1 : pl2_q; // R8
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			valve_q <= 3'h0;
			weld_q <= 1'b0;
			cc_q <= 1'b0;
			heat_q <= 7'h0;
			cur_q <= 14'h0;
		end else begin
			valve_q <= vopen ? valve_sel : 3'h0; // R4 R14 R15
			weld_q <= firing;
			cc_q <= firing && cc;
			heat_q <= firing && !cc ? heat_d : 7'h0; // R5
			cur_q <= firing && cc ? cur_d : 14'h0; // R5
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sched_lock_a: assert property (ext_sel && wr_ctrl |=> $stable(ctrl_q[5:0])) // R1
		else $error("schedule index changed while external");
	alt_sched_a: assert property (st_q == wss_pkg::ST_IDLE && start && second_initiation_input |=>
		run_q == wss_pkg::SCHED_ALT) // R24
		else $error("second initiation did not pick schedule 20");
	first_order_a: assert property (st_q == wss_pkg::ST_W1 && done && !esc_chain |-> st_d == wss_pkg::ST_C1) // R27
		else $error("first weld not followed by first cool");
	zero_skip_a: assert property (cnt == 7'h0 && busy && !loading |-> st_d != st_q) // R26
		else $error("zero count phase not skipped");
	impulse_end_a: assert property (st_q == wss_pkg::ST_C2 && done && !esc_chain && imp_q + 7'h1 >= n_imp |->
		st_d == wss_pkg::ST_HOLD) // R13
		else $error("extra main weld impulse");
	cool_dry_a: assert property ($past(st_q) inside {wss_pkg::ST_C1, wss_pkg::ST_C2, wss_pkg::ST_HOLD} |->
		!weld_on && valve_out == valve_sel) // R10 R12 R14
		else $error("current during cool or hold");
	off_release_a: assert property ($past(st_q) == wss_pkg::ST_OFF |-> valve_out == 3'h0 && !weld_on) // R15
		else $error("valves not released in off");
	single_shot_a: assert property (st_q == wss_pkg::ST_OFF && done && cmode == wss_pkg::CM_NONREP |->
		st_d == wss_pkg::ST_IDLE ##1 !start[*2]) // R18
		else $error("non-repeat restarted without release");
	stop_lock_a: assert property (lock_q && st_q == wss_pkg::ST_IDLE |=> st_q == wss_pkg::ST_IDLE) // R25
		else $error("weld started while locked");
	prelow_one_a: assert property (mon1 && plc1 != 7'h0 && pl1_q == plc1 && $past(pl1_q) != plc1 |-> err_q[2]) // R7
		else $error("first weld pre-low error missing");
	prelow_two_a: assert property (mon2 && plc2 != 7'h0 && pl2_q == plc2 && $past(pl2_q) != plc2 |-> err_q[3]) // R8
		else $error("main weld pre-low error missing");

	chain_c: cover property (st_q == wss_pkg::ST_OFF && st_d == wss_pkg::ST_LOAD && cmode == wss_pkg::CM_CHAIN);
	repeat_c: cover property (st_q == wss_pkg::ST_OFF && st_d == wss_pkg::ST_LOAD && cmode == wss_pkg::CM_REP);
	prelow_c: cover property (err_set[2]);
	escape_c: cover property (esc_chain);
endmodule

// File: bench/wss_power_model.sv
`timescale 1ns/1ps
// Stand-in for the AC line and the power stage: crossings at a fixed rate, current follows the setpoint
module wss_power_model #(
	parameter int HALF = 20
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic weld_on,
	input wire logic [13:0] current_set,
	input wire logic [6:0] heat_pct,
	input wire logic [6:0] scale_pct,
	output logic line_zero,
	output logic [13:0] meas_current,
	output logic [6:0] phase_needed
);
	int cnt;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			line_zero <= 1'b0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			line_zero <= ~line_zero;
		end else begin
			cnt <= cnt + 1;
		end
	end
	// Stage gain scales the delivered current; nothing flows while not firing
	assign meas_current = weld_on ? 14'((32'(current_set) * 32'(scale_pct)) / 100) : 14'h0;
	assign phase_needed = weld_on ? heat_pct : 7'h0;
endmodule

// File: bench/wss_sequencer_test.sv
`timescale 1ns/1ps
module wss_sequencer_test;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, line_zero, weld_on, const_current, er;
	logic init1 = 1'b0, init2 = 1'b0, esc = 1'b0, mon_clr = 1'b0, inpre = 1'b0;
	logic [3:0] sbits = 4'h0;
	logic [6:0] scale = 7'h64;
	logic [13:0] meas_current, current_set;
	logic [6:0] phase_needed, heat_pct;
	logic [2:0] valve_out, vmask;
	logic lz_d, won_d, vz_d;
	logic [6:0] heats [4];
	logic [31:0] w [8];
	int pre, rises, runs, bad_count, samples_checked;

	always #50 pclk = ~pclk;

	wss_sequencer u_wss_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .line_zero(line_zero), .first_initiation_input(init1),
		.second_initiation_input(init2), .escape_in(esc), .schedule_bit_input_a(sbits[0]),
		.schedule_bit_input_b(sbits[1]), .schedule_bit_input_c(sbits[2]),
		.schedule_bit_input_d(sbits[3]), .meas_current(meas_current), .phase_needed(phase_needed),
		.valve_out(valve_out), .weld_on(weld_on), .const_current(const_current),
		.heat_pct(heat_pct), .current_set(current_set));

	wss_power_model u_wss_power_model (.pclk(pclk), .presetn(presetn), .weld_on(weld_on),
		.current_set(current_set), .heat_pct(heat_pct), .scale_pct(scale), .line_zero(line_zero),
		.meas_current(meas_current), .phase_needed(phase_needed));

	////////////////////////////////////////////////////////////////
	// Tracks each run: line cycles before the first weld, weld pulses and their heat
	always @(posedge pclk) begin
		lz_d <= line_zero;
		won_d <= weld_on;
		vz_d <= valve_out != 3'h0;
		if (mon_clr) begin
			pre <= 0;
			rises <= 0;
			runs <= 0;
		end else begin
			if (valve_out != 3'h0 && !vz_d) begin
				runs <= runs + 1;
				pre <= 0;
				inpre <= 1'b1;
				vmask <= valve_out;
			end else if (line_zero && !lz_d && inpre) begin
				pre <= pre + 1;
			end
			if (weld_on && !won_d) begin
				rises <= rises + 1;
				inpre <= 1'b0;
				heats[rises[1:0]] <= heat_pct;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Ready and data are taken at the rising edge that completes the access
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 100);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(32'(k < 100), 32'h1);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdx(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic load(input logic [5:0] idx);
		for (int i = 0; i < 8; i++) begin
			wr(12'h800 | {1'b0, idx, 5'h00} | 12'(i * 4), w[i]);
		end
	endtask

	task automatic clr;
		@(posedge pclk);
		mon_clr <= 1'b1;
		@(posedge pclk);
		mon_clr <= 1'b0;
	endtask

	// Start just after a line crossing so no crossing meets the valve edge
	task automatic start;
		do @(posedge pclk); while (!(line_zero && !lz_d));
		init1 <= 1'b1;
	endtask

	task automatic wait_rise(input int n);
		int k;
		k = 0;
		while (rises < n && k < 5000) begin
			@(posedge pclk);
			k++;
		end
		chk(32'(k < 5000), 32'h1);
	endtask

	task automatic wait_idle;
		int k;
		k = 0;
		repeat (20) @(posedge pclk);
		do begin
			rdx(wss_pkg::A_STAT);
			k++;
		end while (rd[8] !== 1'b0 && k < 500);
		chk(32'(rd[8] === 1'b0), 32'h1);
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rdx(wss_pkg::A_CTRL);
		chk(rd, wss_pkg::CTRL_RST);
		rdx(wss_pkg::A_OFFS);
		chk(rd, wss_pkg::OFFS_RST);
		rdx(12'h010);
		chk({rd[30:0], er}, 32'h1);
	endtask

	task automatic t_single;
		w = '{32'h0205_0302, 32'h0201_1e02, 32'h0000_8000, 32'h0014_0000, 32'h0201_3c03, 32'h0, 32'h0, 32'h2};
		load(6'h00);
		rdx(12'h810);
		chk(rd, w[4]);
		clr;
		start;
		wait_rise(3);
		wait_idle;
		chk(32'(pre), 32'd5);
		chk(32'(vmask), 32'h5);
		chk(32'(rises), 32'd3);
		chk({heats[0], heats[1], heats[2], 11'h0}, {7'd30, 7'd40, 7'd60, 11'h0});
		repeat (300) @(posedge pclk);
		chk(32'(runs), 32'd1);
		init1 <= 1'b0;
	endtask

	task automatic t_repeat;
		wr(12'h800, 32'h0215_0302);
		clr;
		start;
		wait_rise(4);
		chk(32'(runs), 32'd2);
		chk(32'(pre), 32'd3);
		init1 <= 1'b0;
		wait_idle;
		rdx(wss_pkg::A_STAT);
		chk(32'(rd[21:16]), 32'h10);
		wr(wss_pkg::A_ECLR, 32'h003f_0000);
	endtask

	task automatic t_const_err;
		w = '{32'h0102_0100, 32'h83, 32'h0a0a_43e8, 32'h0000_0205, 32'h0100_0000, 32'h0, 32'h0, 32'h1};
		load(6'h01);
		wr(wss_pkg::A_CTRL, 32'h0005_0201);
		wr(wss_pkg::A_OFFS, 32'h0000_0109);
		scale <= 7'd80;
		clr;
		start;
		wait_rise(1);
		chk(32'({const_current, heat_pct, current_set}), 32'({1'b1, 7'h0, 14'd1050}));
		init1 <= 1'b0;
		wait_idle;
		rdx(wss_pkg::A_STAT);
		chk(32'({rd[21:16], rd[9]}), 32'h0b);
		clr;
		init1 <= 1'b1;
		repeat (300) @(posedge pclk);
		chk(32'(runs), 32'd0);
		init1 <= 1'b0;
		wr(wss_pkg::A_ECLR, 32'h003f_0000);
		rdx(wss_pkg::A_STAT);
		chk(32'({rd[21:16], rd[9]}), 32'h0);
	endtask

	task automatic t_ext;
		wr(12'h800, 32'h0225_0302);
		wr(wss_pkg::A_CTRL, 32'h0);
		clr;
		start;
		wait_rise(4);
		rdx(wss_pkg::A_STAT);
		chk(32'(rd[5:0]), 32'h1);
		chk(32'(runs), 32'd2);
		init1 <= 1'b0;
		wait_idle;
		load(6'h14);
		wr(wss_pkg::A_CTRL, 32'h0000_0100);
		wr(wss_pkg::A_CTRL, 32'h0000_0107);
		rdx(wss_pkg::A_CTRL);
		chk(rd, 32'h0000_0100);
		sbits <= 4'h1;
		clr;
		start;
		wait_rise(1);
		rdx(wss_pkg::A_STAT);
		chk(32'(rd[5:0]), 32'h1);
		init1 <= 1'b0;
		wait_idle;
		clr;
		init2 <= 1'b1;
		wait_rise(1);
		rdx(wss_pkg::A_STAT);
		chk(32'(rd[5:0]), 32'd20);
		init2 <= 1'b0;
		wait_idle;
	endtask

	////////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_single;
		t_repeat;
		t_const_err;
		t_ext;
		complete_run;
	end

	initial begin
		#(100 * 30000);
		bad_count++;
		complete_run;
	end
endmodule
